// File: shared/irq_flag_bank_map.vh
// What this block does
// - each request flag is set by its source event whatever its enable bit is.
// - a set flag stays set until software clears it, except the summary bit, which follows its source; a clear flag means no event since the clear.
// - every request flag except the live summary bit is 0 after reset.
// - each external interrupt takes its pin from its own pin-select register.
// - first register bit 4 is channel 1 source count, bits 3..1 external 2..0, bit 0 software.
// - index 0x46A holds channel 2 flags in bits 3..0 and channel 3 in bits 7..4.
// - index 0x46B holds tuning, scanner, checksum, nonvolatile, then channel 4 flags in 3..0.
// - index 0x46C holds timer1 gate, timer1, timer0, summary, supply 3, supply 2, osc, switch.
// - the first register is at index 0x469 with channel 1 abort, overrun, dest count in 7..5.
`ifndef IRQ_FLAG_BANK_MAP_VH
`define IRQ_FLAG_BANK_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_DMA1_EXTERNAL_SOFT_FLAGS 12'h469
`define IDX_DMA_CH2_CH3_EVENT_FLAGS  12'h46a
`define IDX_SYSTEM_DMA4_EVENT_FLAGS  12'h46b
`define IDX_TIMER_CLOCK_SUPPLY_FLAGS 12'h46c
`define IDX_IRQ_STATUS               12'h480
`define IDX_IRQ_CLEAR                12'h481
`define IDX_IRQ_ENABLE               12'h482
`define IDX_EXT_PIN_SELECT0          12'h483
`define IDX_EXT_PIN_SELECT1          12'h484
`define IDX_EXT_PIN_SELECT2          12'h485

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define DMA_ABORT_BIT        3
`define DMA_OVERRUN_BIT      2
`define DMA_DEST_COUNT_BIT   1
`define DMA_SOURCE_COUNT_BIT 0
`define SOFTWARE_REQUEST_BIT 0
`define PIN_CHANGE_SUMMARY_BIT 4
`define SEL_WIDTH            3

// bits that hold storage; the summary bit is a live read-only view
`define WRITABLE_REG0 8'hff
`define WRITABLE_REG1 8'hff
`define WRITABLE_REG2 8'hff
`define WRITABLE_REG3 8'hef

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IRQ_FLAG_RESET   8'h00
`define IRQ_ENABLE_RESET 32'h00000000
`define EXT_SEL_RESET    3'h0

`endif

// File: hdl/flag_register.v
`timescale 1ns/1ps
`include "irq_flag_bank_map.vh"

// one byte of sticky request flags
module flag_register #(
    parameter [7:0] WRITABLE = 8'hff
) (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // hardware events and software access
    input  wire [7:0] hw_set,
    input  wire       sw_write,
    input  wire [7:0] sw_data,
    input  wire [7:0] sw_clear,
    // stored flags
    output reg  [7:0] flags
);

    reg [7:0] next_flags;

    // software first, then events on top so a same-cycle event is never lost
    always @* begin
        next_flags = flags & ~sw_clear;
        if (sw_write) begin
            next_flags = sw_data;
        end
        next_flags = (next_flags | hw_set) & WRITABLE;
    end

    // hardware never clears a flag on its own
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `IRQ_FLAG_RESET;
        end else begin
            flags <= next_flags;
        end
    end

endmodule

// File: hdl/peripheral_irq_flag_bank.v
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "irq_flag_bank_map.vh"

module peripheral_irq_flag_bank (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // dma channel events: abort, overrun, dest count, source count
    input  wire [3:0]  dma_ch1_events,
    input  wire [3:0]  dma_ch2_events,
    input  wire [3:0]  dma_ch3_events,
    input  wire [3:0]  dma_ch4_events,
    // external interrupt pins
    input  wire [7:0]  gpio_pins,
    // system events
    input  wire        clock_tuning_event,
    input  wire        memory_scanner_event,
    input  wire        checksum_unit_event,
    input  wire        nonvolatile_memory_event,
    input  wire        timer1_gate_event,
    input  wire        timer1_event,
    input  wire        timer0_event,
    input  wire        pin_change_summary,
    input  wire        supply_domain3_event,
    input  wire        supply_domain2_event,
    input  wire        oscillator_failure_event,
    input  wire        clock_switch_event,
    // towards the processor interrupt logic
    output wire [31:0] irq_requests,
    output wire        irq
);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire [11:0] word_index;
    wire        setup_phase;
    wire        access_phase;
    wire        hit;
    wire        bus_write;
    wire        lane0_write;

    assign word_index   = paddr[13:2];
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;

    // every register answers at once; no wait states are ever inserted
    assign pready = 1'b1;

    // only aligned words at known indices; paddr[15:14] is not decoded, so the 14-bit window repeats
    assign hit = (paddr[1:0] == 2'b00) & (
                 (word_index == `IDX_DMA1_EXTERNAL_SOFT_FLAGS) |
                 (word_index == `IDX_DMA_CH2_CH3_EVENT_FLAGS) |
                 (word_index == `IDX_SYSTEM_DMA4_EVENT_FLAGS) |
                 (word_index == `IDX_TIMER_CLOCK_SUPPLY_FLAGS) |
                 (word_index == `IDX_IRQ_STATUS) |
                 (word_index == `IDX_IRQ_CLEAR) |
                 (word_index == `IDX_IRQ_ENABLE) |
                 (word_index == `IDX_EXT_PIN_SELECT0) |
                 (word_index == `IDX_EXT_PIN_SELECT1) |
                 (word_index == `IDX_EXT_PIN_SELECT2));

    assign pslverr     = access_phase & ~hit;
    assign bus_write   = access_phase & pwrite & hit;
    assign lane0_write = bus_write & pstrb[0];

    // ----------------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------------
    wire        wr_reg0;
    wire        wr_reg1;
    wire        wr_reg2;
    wire        wr_reg3;
    wire        wr_clear;
    wire        wr_sel0;
    wire        wr_sel1;
    wire        wr_sel2;
    wire [31:0] lane_mask;
    wire [31:0] clear_bits;

    assign wr_reg0  = lane0_write & (word_index == `IDX_DMA1_EXTERNAL_SOFT_FLAGS);
    assign wr_reg1  = lane0_write & (word_index == `IDX_DMA_CH2_CH3_EVENT_FLAGS);
    assign wr_reg2  = lane0_write & (word_index == `IDX_SYSTEM_DMA4_EVENT_FLAGS);
    assign wr_reg3  = lane0_write & (word_index == `IDX_TIMER_CLOCK_SUPPLY_FLAGS);
    assign wr_clear = bus_write & (word_index == `IDX_IRQ_CLEAR);
    assign wr_sel0  = lane0_write & (word_index == `IDX_EXT_PIN_SELECT0);
    assign wr_sel1  = lane0_write & (word_index == `IDX_EXT_PIN_SELECT1);
    assign wr_sel2  = lane0_write & (word_index == `IDX_EXT_PIN_SELECT2);

    // byte strobes widened to a bit mask for the 32-bit registers
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // write-one-to-clear view of all four flag bytes
    assign clear_bits = wr_clear ? (pwdata & lane_mask) : 32'h00000000;

    // ----------------------------------------------------------------
    // external pin selection
    // ----------------------------------------------------------------
    reg  [`SEL_WIDTH-1:0] ext_pin_select [0:2];
    reg  [2:0]            ext_pin_prev;
    wire [2:0]            ext_pin_level;
    wire [2:0]            ext_pin_edge;

    // each channel looks only at the pin its own select names
    assign ext_pin_level[0] = gpio_pins[ext_pin_select[0]];
    assign ext_pin_level[1] = gpio_pins[ext_pin_select[1]];
    assign ext_pin_level[2] = gpio_pins[ext_pin_select[2]];

    // rising edge; a select change onto a high pin also counts as an edge,
    // so software should reselect with the enable off and then clear the flag
    assign ext_pin_edge = ext_pin_level & ~ext_pin_prev;

    // select registers and edge history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pin_select[0] <= `EXT_SEL_RESET;
            ext_pin_select[1] <= `EXT_SEL_RESET;
            ext_pin_select[2] <= `EXT_SEL_RESET;
            ext_pin_prev      <= 3'b000;
        end else begin
            if (wr_sel0) begin
                ext_pin_select[0] <= pwdata[`SEL_WIDTH-1:0];
            end
            if (wr_sel1) begin
                ext_pin_select[1] <= pwdata[`SEL_WIDTH-1:0];
            end
            if (wr_sel2) begin
                ext_pin_select[2] <= pwdata[`SEL_WIDTH-1:0];
            end
            ext_pin_prev <= ext_pin_level;
        end
    end

    // ----------------------------------------------------------------
    // event vectors per flag register
    // ----------------------------------------------------------------
    wire [7:0] set_reg0;
    wire [7:0] set_reg1;
    wire [7:0] set_reg2;
    wire [7:0] set_reg3;

    // software request bit has no hardware source
    assign set_reg0 = {dma_ch1_events, ext_pin_edge, 1'b0};
    assign set_reg1 = {dma_ch3_events, dma_ch2_events};
    assign set_reg2 = {clock_tuning_event, memory_scanner_event,
                       checksum_unit_event, nonvolatile_memory_event,
                       dma_ch4_events};
    assign set_reg3 = {timer1_gate_event, timer1_event, timer0_event, 1'b0,
                       supply_domain3_event, supply_domain2_event,
                       oscillator_failure_event, clock_switch_event};

    // ----------------------------------------------------------------
    // flag storage
    // ----------------------------------------------------------------
    wire [7:0] dma1_external_soft_flags;
    wire [7:0] dma_ch2_ch3_event_flags;
    wire [7:0] system_dma4_event_flags;
    wire [7:0] timer_clock_flags_stored;
    wire [7:0] timer_clock_supply_flags;
    wire [31:0] all_flags;

    flag_register #(.WRITABLE(`WRITABLE_REG0)) u_reg0 (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_set   (set_reg0),
        .sw_write (wr_reg0),
        .sw_data  (pwdata[7:0]),
        .sw_clear (clear_bits[7:0]),
        .flags    (dma1_external_soft_flags)
    );

    flag_register #(.WRITABLE(`WRITABLE_REG1)) u_reg1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_set   (set_reg1),
        .sw_write (wr_reg1),
        .sw_data  (pwdata[7:0]),
        .sw_clear (clear_bits[15:8]),
        .flags    (dma_ch2_ch3_event_flags)
    );

    flag_register #(.WRITABLE(`WRITABLE_REG2)) u_reg2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_set   (set_reg2),
        .sw_write (wr_reg2),
        .sw_data  (pwdata[7:0]),
        .sw_clear (clear_bits[23:16]),
        .flags    (system_dma4_event_flags)
    );

    flag_register #(.WRITABLE(`WRITABLE_REG3)) u_reg3 (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_set   (set_reg3),
        .sw_write (wr_reg3),
        .sw_data  (pwdata[7:0]),
        .sw_clear (clear_bits[31:24]),
        .flags    (timer_clock_flags_stored)
    );

    // summary bit is the live pin-change state; it clears at its source only
    assign timer_clock_supply_flags = timer_clock_flags_stored |
        ({7'h00, pin_change_summary} << `PIN_CHANGE_SUMMARY_BIT);

    assign all_flags = {timer_clock_supply_flags, system_dma4_event_flags,
                        dma_ch2_ch3_event_flags, dma1_external_soft_flags};

    // ----------------------------------------------------------------
    // enable and request outputs
    // ----------------------------------------------------------------
    reg [31:0] irq_enable;

    // software is expected to clear a flag before enabling it, otherwise a
    // stale event is raised the moment the enable goes high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= `IRQ_ENABLE_RESET;
        end else if (bus_write & (word_index == `IDX_IRQ_ENABLE)) begin
            irq_enable <= (irq_enable & ~lane_mask) | (pwdata & lane_mask);
        end
    end

    // gating happens outside the flags, so flags latch regardless of enable
    assign irq_requests = all_flags & irq_enable;
    assign irq          = |irq_requests;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    reg [31:0] next_rdata;

    // read mux; clear register and unmapped words read as zero
    always @* begin
        next_rdata = 32'h00000000;
        case (word_index)
            `IDX_DMA1_EXTERNAL_SOFT_FLAGS: begin
                next_rdata = {24'h000000, dma1_external_soft_flags};
            end
            `IDX_DMA_CH2_CH3_EVENT_FLAGS: begin
                next_rdata = {24'h000000, dma_ch2_ch3_event_flags};
            end
            `IDX_SYSTEM_DMA4_EVENT_FLAGS: begin
                next_rdata = {24'h000000, system_dma4_event_flags};
            end
            `IDX_TIMER_CLOCK_SUPPLY_FLAGS: begin
                next_rdata = {24'h000000, timer_clock_supply_flags};
            end
            `IDX_IRQ_STATUS: begin
                next_rdata = all_flags;
            end
            `IDX_IRQ_ENABLE: begin
                next_rdata = irq_enable;
            end
            `IDX_EXT_PIN_SELECT0: begin
                next_rdata = {29'h00000000, ext_pin_select[0]};
            end
            `IDX_EXT_PIN_SELECT1: begin
                next_rdata = {29'h00000000, ext_pin_select[1]};
            end
            `IDX_EXT_PIN_SELECT2: begin
                next_rdata = {29'h00000000, ext_pin_select[2]};
            end
            default: begin
                next_rdata = 32'h00000000;
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            next_rdata = 32'h00000000;
        end
    end

    // captured in the setup cycle so prdata is a flop during the access cycle;
    // an event landing between the two cycles shows on the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase & ~pwrite) begin
            prdata <= next_rdata;
        end
    end

endmodule

// File: bench/irq_flag_bank_checker.sv
`timescale 1ns/1ps
module irq_flag_bank_checker (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] prdata,
    // events and requests
    input wire        timer0_event,
    input wire        pin_change_summary,
    input wire [31:0] irq_requests,
    input wire        irq
);
    // ----------------------------------------------------------------
    // bus and request relations
    // ----------------------------------------------------------------
    wire acc = psel && penable;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // the summary bit is live, so it may drop without software
    a_reset_clean: assert property ($rose(presetn) |-> irq_requests == 32'h0 && !irq)
        else $error("requests up at reset release");
    a_irq_is_or: assert property (irq == (|irq_requests))
        else $error("irq differs from request or");
    a_flag_sticky: assert property ((($past(irq_requests) & ~irq_requests & 32'hefffffff)
        != 32'h0) |-> $past(acc && pwrite)) else $error("request dropped without a write");
    a_timer0_cause: assert property ($rose(irq_requests[29]) |->
        $past(timer0_event) || $past(acc && pwrite)) else $error("timer0 request w/o cause");
    a_summary_live: assert property (irq_requests[28] |-> pin_change_summary)
        else $error("summary request without source");
    a_pready_up: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> acc)
        else $error("error outside access");
    a_byte_read: assert property (acc && !pwrite && paddr[13:2] == 12'h469 |->
        prdata[31:8] == 24'h0) else $error("upper read bits set");
    a_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
endmodule

bind peripheral_irq_flag_bank irq_flag_bank_checker irq_flag_bank_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .timer0_event(timer0_event), .pin_change_summary(pin_change_summary),
    .irq_requests(irq_requests), .irq(irq));

// File: bench/event_source_model.sv
`timescale 1ns/1ps
module event_source_model (
    // clock
    input  wire        pclk,
    // pulse requests in flag layout
    input  wire [31:0] fire,
    // event pulses in flag layout
    output reg  [31:0] events
);
    // registered so each pulse lasts as many whole cycles as its fire request, blind to enables
    initial events = 32'h0;
    always @(posedge pclk) begin
        events <= fire;
    end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "irq_flag_bank_map.vh"
module tb_top;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [15:0] paddr = 16'h0;
    reg  [31:0] pwdata = 32'h0;
    reg  [31:0] fire = 32'h0;
    reg  [7:0]  gpio_pins = 8'h0;
    wire        pready;
    wire        pslverr;
    wire        irq;
    wire [31:0] prdata;
    wire [31:0] irq_requests;
    wire [31:0] events;
    reg  [31:0] rd;
    reg         err;
    reg  [51:0] rows [0:8];
    integer     miscompares = 0;
    integer     checks = 0;
    integer     i;

    always #25 pclk = ~pclk;

    // event bits follow the flag layout, so one vector feeds every source but the gpio pins
    peripheral_irq_flag_bank peripheral_irq_flag_bank_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .dma_ch1_events(events[7:4]), .dma_ch2_events(events[11:8]),
        .dma_ch3_events(events[15:12]), .dma_ch4_events(events[19:16]), .gpio_pins(gpio_pins),
        .clock_tuning_event(events[23]), .memory_scanner_event(events[22]),
        .checksum_unit_event(events[21]), .nonvolatile_memory_event(events[20]),
        .timer1_gate_event(events[31]), .timer1_event(events[30]), .timer0_event(events[29]),
        .pin_change_summary(events[28]), .supply_domain3_event(events[27]),
        .supply_domain2_event(events[26]), .oscillator_failure_event(events[25]),
        .clock_switch_event(events[24]), .irq_requests(irq_requests), .irq(irq));

    event_source_model event_source_model_inst (.pclk(pclk), .fire(fire), .events(events));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    // ev is pulsed so it lands in the access cycle, racing the write
    task apb(input w, input [11:0] idx, input [31:0] wd, input [31:0] ev);
        integer n;
        begin
            n = 0;
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {2'b00, idx, 2'b00};
            pwdata <= wd;
            fire <= ev;
            @(posedge pclk);
            penable <= 1'b1;
            fire <= 32'h0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge pclk);
            end
            // a slave that never answers is a failure, not a silent pass
            if (pready !== 1'b1) begin
                miscompares = miscompares + 1;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
                miscompares = miscompares + 1;
            end
        end
    endtask

    task rc(input [11:0] idx, input [31:0] exp);
        begin
            apb(1'b0, idx, 32'h0, 32'h0);
            chk(rd, exp);
        end
    endtask

    task pulse(input [31:0] v);
        begin
            fire <= v;
            @(posedge pclk);
            fire <= 32'h0;
            repeat (2) @(posedge pclk);
        end
    endtask

    task close_out;
        begin
            $display("checks=%0d miscompares=%0d", checks, miscompares);
            if (miscompares == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    // rows: event vector, register index, expected byte
    initial begin
        rows[0] = 52'h00000080_469_80;
        rows[1] = 52'h00000010_469_10;
        rows[2] = 52'h00000100_46a_01;
        rows[3] = 52'h00008000_46a_80;
        rows[4] = 52'h00800000_46b_80;
        rows[5] = 52'h00010000_46b_01;
        rows[6] = 52'h80000000_46c_80;
        rows[7] = 52'h20000000_46c_20;
        rows[8] = 52'h01000000_46c_01;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 12'h469; i <= 12'h46c; i = i + 1)
            rc(i[11:0], 32'h0);
        rc(`IDX_IRQ_ENABLE, 32'h0);
        for (i = 0; i < 9; i = i + 1) begin
            pulse(rows[i][51:20]);
            rc(rows[i][19:8], {24'h0, rows[i][7:0]});
            chk({31'h0, irq}, 32'h0);
            rc(`IDX_IRQ_STATUS, rows[i][51:20]);
            apb(1'b1, `IDX_IRQ_CLEAR, rows[i][51:20], 32'h0);
            rc(`IDX_IRQ_STATUS, 32'h0);
        end
        apb(1'b1, 12'h469, 32'h1, 32'h0);
        rc(12'h469, 32'h1);
        apb(1'b1, 12'h469, 32'h0, 32'h0);
        // all selects reset to pin 0, so one edge hits all three
        gpio_pins <= 8'h01;
        repeat (3) @(posedge pclk);
        rc(12'h469, 32'h0e);
        gpio_pins <= 8'h00;
        apb(1'b1, 12'h469, 32'h0, 32'h0);
        apb(1'b1, `IDX_EXT_PIN_SELECT1, 32'h3, 32'h0);
        gpio_pins <= 8'h08;
        repeat (3) @(posedge pclk);
        rc(12'h469, 32'h04);
        // clear the external flag so the status reads below see only timer bits
        apb(1'b1, 12'h469, 32'h0, 32'h0);
        rc(12'h46c, 32'h0);
        apb(1'b1, `IDX_IRQ_ENABLE, 32'h20000000, 32'h0);
        pulse(32'h20000000);
        chk({31'h0, irq}, 32'h1);
        chk(irq_requests, 32'h20000000);
        apb(1'b1, `IDX_IRQ_ENABLE, 32'h0, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rc(`IDX_IRQ_STATUS, 32'h20000000);
        apb(1'b1, 12'h46c, 32'h0, 32'h20000000);
        rc(12'h46c, 32'h20);
        apb(1'b1, `IDX_IRQ_ENABLE, 32'h30000000, 32'h0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `IDX_IRQ_CLEAR, 32'h20000000, 32'h0);
        chk({31'h0, irq}, 32'h0);
        pulse(32'h10000000);
        // summary is live: it follows its source and needs no software clear
        fire <= 32'h10000000;
        repeat (2) @(posedge pclk);
        chk(irq_requests, 32'h10000000);
        fire <= 32'h0;
        repeat (2) @(posedge pclk);
        chk(irq_requests, 32'h0);
        apb(1'b1, 12'h46c, 32'h10, 32'h0);
        rc(12'h46c, 32'h0);
        apb(1'b1, `IDX_IRQ_STATUS, 32'hffffffff, 32'h0);
        rc(`IDX_IRQ_STATUS, 32'h0);
        rc(12'h470, 32'h0);
        chk({31'h0, err}, 32'h1);
        close_out;
    end

    // a hang ends the run the same way as the tests do
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares = miscompares + 1;
        close_out;
    end
endmodule
